// [frwp_ctrl.sv]
// reset, write-enable and array protection control for a serial flash
// What this block does
// R1: software reset needs 66h then 99h consecutively
// R2: software reset lasts 30us, rejecting all commands but status read
// R3: restart pin low 1us restores power-on state
// R4: qualified restart pulse overrides and aborts everything
// R5: write-type commands refused until power-up delay ends
// R6: write enable latch clears on power-up
// R7: program, erase, status write need write enable
// R8: latch set by enable, cleared by disable/completion
// R9: power-down ignores all but release command
// R10: lock bits: 510 blocks plus 32 sectors
// R11: locked regions ignore program and erase
// R12: locks all set at power-on; 39h unlocks
// R13: scheme select picks range bits or locks
// R14: busy bit high while operation executes
// R15: busy ignores all but status read
// R16: four block-protect bits choose protected range
// R17: top/bottom bit picks range origin
// R18: complement bit inverts protected range
// R19: status writes gated by lock, latch, pin
// R20: other command cancels a pending reset enable
// R21: serial link works in modes 0 and 3
// R22: chip select must fall before first instruction
module frwp_ctrl
    import frwp_pkg::*;
#(
    parameter int PUW_CYC = 100000,
    parameter int SRW_CYC = 1000
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe,
    input wire logic restart_n,
    input wire logic wp_n,
    input wire logic supply_ok,
    input wire logic array_done,
    output logic array_go,
    output logic [1:0] array_kind,
    output logic [ADDR_W-1:0] array_addr,
    output logic array_abort,
    output logic [7:0] status_one
);
    logic [1:0] cs_sy_r, rs_sy_r, wp_sy_r, ok_sy_r, tg_sy_r;
    logic cs_prev_r, tg_prev_r;
    logic [7:0] rx_byte;
    logic rx_tgl;
    logic [PUB_W-1:0] pub_r;
    logic [7:0] rs_cnt_r;
    logic [31:0] puw_cnt_r, tmr_r;
    frwp_st_e st_r;
    logic sr_op_r, wel_r, pd_r, pend_r, armed_r;
    logic [2:0] cnt_r;
    logic [7:0] cmd_r, dat_r;
    logic [31:0] addr_r;
    logic [3:0] bp_r;
    logic tb_r, srp_r, cmp_r, srl_r, wps_r;
    logic [LOCK_BITS-1:0] lock_r;

    function automatic logic bp_hit(input logic [8:0] blk, input logic [3:0] bp,
        input logic tb, input logic cmp);
        logic [9:0] n;
        logic in_range;
        n = (bp == 4'h0) ? 10'h0 : (bp >= 4'ha) ? 10'h200 : (10'h1 << (bp - 4'h1));
        in_range = tb ? ({1'b0, blk} < n) : ({1'b0, blk} >= 10'h200 - n);
        return in_range ^ cmp;
    endfunction : bp_hit

    function automatic logic [9:0] lock_idx(input logic [ADDR_W-1:0] a);
        if (a[24:16] == 9'h0) begin
            return {6'h0, a[15:12]};
        end else if (a[24:16] == 9'h1ff) begin
            return {6'h1, a[15:12]};
        end
        return {1'b0, a[24:16]} + 10'h1f;
    endfunction : lock_idx

    frwp_spi_link u_link (
        .spi_sclk(spi_sclk),
        .spi_cs_n(spi_cs_n),
        .spi_mosi(spi_mosi),
        .pub_word(pub_r),
        .rx_byte(rx_byte),
        .rx_tgl(rx_tgl),
        .spi_miso(spi_miso),
        .spi_miso_oe(spi_miso_oe)
    );

    always_ff @(posedge clk) begin
        if (rst) begin
            cs_sy_r <= 2'h3;
            rs_sy_r <= 2'h3;
            wp_sy_r <= 2'h3;
            ok_sy_r <= 2'h0;
            tg_sy_r <= 2'h0;
        end else begin
            cs_sy_r <= {cs_sy_r[0], spi_cs_n};
            rs_sy_r <= {rs_sy_r[0], restart_n};
            wp_sy_r <= {wp_sy_r[0], wp_n};
            ok_sy_r <= {ok_sy_r[0], supply_ok};
            tg_sy_r <= {tg_sy_r[0], rx_tgl};
        end
    end

    wire cs_q = cs_sy_r[1];
    wire frame_end = cs_q && !cs_prev_r;
    wire frame_start = !cs_q && cs_prev_r;
    wire byte_ev = tg_sy_r[1] ^ tg_prev_r;
    wire pwr_rst = rst || !ok_sy_r[1];
    wire hw_hold = rs_cnt_r == 8'(RESTART_CYC); // see R3
    wire sw_done = (st_r == ST_SWRST) && (tmr_r == 32'h0);
    wire ires = pwr_rst || hw_hold || sw_done; // see R4
    wire puw_done = puw_cnt_r == 32'(PUW_CYC);
    wire busy = st_r == ST_BUSY; // see R14

    // frame decision, taken when chip select returns high
    wire go_frame = frame_end && armed_r && cnt_r != 3'h0 && st_r == ST_IDLE; // see R15
    wire acc = go_frame && (!pd_r || cmd_r == OP_RPD); // see R9
    wire full_addr = cnt_r >= 3'h5;
    wire [ADDR_W-1:0] op_addr = addr_r[ADDR_W-1:0];
    wire [8:0] op_blk = op_addr[24:16];
    wire is_arr = cmd_r == OP_PROG || cmd_r == OP_SERASE || cmd_r == OP_BERASE
        || cmd_r == OP_CERASE;
    wire is_srw = cmd_r == OP_WRSR1 || cmd_r == OP_WRSR2 || cmd_r == OP_WRSR3;
    wire [1:0] kind_sel = (cmd_r == OP_SERASE) ? KIND_SERASE :
        (cmd_r == OP_BERASE) ? KIND_BERASE :
        (cmd_r == OP_CERASE) ? KIND_CERASE : KIND_PROG;
    wire wr_allow = wel_r && puw_done; // see R5
    wire sr_allow = wr_allow && !srl_r && !(srp_r && !wp_sy_r[1]); // see R19
    wire lock_hit = (kind_sel == KIND_CERASE) ? |lock_r :
        (kind_sel == KIND_BERASE && op_blk == 9'h0) ? |lock_r[15:0] :
        (kind_sel == KIND_BERASE && op_blk == 9'h1ff) ? |lock_r[31:16] :
        lock_r[lock_idx(op_addr)]; // see R10
    wire bp_any = cmp_r ? (bp_r < 4'ha) : (bp_r != 4'h0);
    wire range_hit = (kind_sel == KIND_CERASE) ? bp_any
        : bp_hit(op_blk, bp_r, tb_r, cmp_r); // see R16 see R17 see R18
    wire prot = wps_r ? lock_hit : range_hit; // see R13 see R11
    wire arr_go = acc && is_arr && wr_allow && !prot
        && (full_addr || kind_sel == KIND_CERASE); // see R7
    wire sr_go = acc && is_srw && sr_allow && cnt_r >= 3'h2;
    wire sw_go = acc && pend_r && cmd_r == OP_RST; // see R1
    wire op_end = busy && (sr_op_r ? tmr_r == 32'h0 : array_done);

    always_ff @(posedge clk) begin
        if (rst) begin
            cs_prev_r <= 1'b1;
            tg_prev_r <= 1'b0;
            rs_cnt_r <= 8'h0;
            puw_cnt_r <= 32'h0;
        end else begin
            cs_prev_r <= cs_q;
            tg_prev_r <= tg_sy_r[1];
            rs_cnt_r <= rs_sy_r[1] ? 8'h0 : (hw_hold ? rs_cnt_r : rs_cnt_r + 8'h1);
            puw_cnt_r <= !ok_sy_r[1] ? 32'h0 : (puw_done ? puw_cnt_r : puw_cnt_r + 32'h1);
        end
    end

    // byte collection within a frame
    always_ff @(posedge clk) begin
        if (rst || frame_start) begin
            cnt_r <= 3'h0;
            cmd_r <= 8'h0;
            dat_r <= 8'h0;
            addr_r <= 32'h0;
        end else if (byte_ev) begin
            cnt_r <= (cnt_r == 3'h7) ? cnt_r : cnt_r + 3'h1;
            if (cnt_r == 3'h0) begin
                cmd_r <= rx_byte;
            end
            if (cnt_r == 3'h1) begin
                dat_r <= rx_byte;
            end
            if (cnt_r != 3'h0 && cnt_r < 3'h5) begin
                addr_r <= {addr_r[23:0], rx_byte};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (ires) begin
            st_r <= ST_IDLE;
            sr_op_r <= 1'b0;
            tmr_r <= 32'h0;
        end else begin
            case (st_r)
                ST_IDLE: begin
                    if (sw_go) begin
                        st_r <= ST_SWRST; // see R2
                        tmr_r <= 32'(SWRESET_CYC - 1);
                    end else if (arr_go || sr_go) begin
                        st_r <= ST_BUSY;
                        sr_op_r <= sr_go;
                        tmr_r <= 32'(SRW_CYC - 1);
                    end
                end
                ST_BUSY: begin
                    tmr_r <= (tmr_r == 32'h0) ? tmr_r : tmr_r - 32'h1;
                    if (op_end) begin
                        st_r <= ST_IDLE;
                    end
                end
                ST_SWRST: begin
                    tmr_r <= tmr_r - 32'h1;
                end
                default: begin
                    st_r <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (ires) begin
            wel_r <= 1'b0; // see R6
            pd_r <= 1'b0;
            pend_r <= 1'b0;
            armed_r <= 1'b0;
            lock_r <= '1; // see R12
        end else begin
            if (frame_start) begin
                armed_r <= 1'b1; // see R22
            end
            if (acc) begin
                pend_r <= cmd_r == OP_RSTEN; // see R20
            end
            if (acc && cmd_r == OP_PDOWN) begin
                pd_r <= 1'b1;
            end else if (acc && cmd_r == OP_RPD) begin
                pd_r <= 1'b0;
            end
            if (op_end || (acc && cmd_r == OP_WRDI)) begin
                wel_r <= 1'b0; // see R8
            end else if (acc && cmd_r == OP_WREN && puw_done) begin
                wel_r <= 1'b1;
            end
            if (acc && cmd_r == OP_UNLOCK && full_addr) begin
                lock_r[lock_idx(op_addr)] <= 1'b0;
            end
        end
    end

    // protection fields survive restarts and supply loss; the lock-down bit survives only restarts
    always_ff @(posedge clk) begin
        if (rst) begin
            bp_r <= 4'h0;
            tb_r <= 1'b0;
            srp_r <= 1'b0;
            cmp_r <= 1'b0;
            wps_r <= 1'b0;
        end else if (sr_go && cmd_r == OP_WRSR1) begin
            bp_r <= dat_r[SR1_BP +: 4];
            tb_r <= dat_r[SR1_TB];
            srp_r <= dat_r[SR1_SRP];
        end else if (sr_go && cmd_r == OP_WRSR2) begin
            cmp_r <= dat_r[SR2_CMP];
        end else if (sr_go && cmd_r == OP_WRSR3) begin
            wps_r <= dat_r[SR3_WPS];
        end
    end

    always_ff @(posedge clk) begin
        if (pwr_rst) begin
            srl_r <= 1'b0;
        end else if (sr_go && cmd_r == OP_WRSR2 && dat_r[SR2_SRL]) begin
            srl_r <= 1'b1;
        end
    end

    wire [7:0] sr1 = {srp_r, tb_r, bp_r, wel_r, busy};
    wire [7:0] sr2 = {1'b0, cmp_r, 5'h0, srl_r};
    wire [7:0] sr3 = {5'h0, wps_r, 2'h0};

    // published word only changes while the link is deselected
    always_ff @(posedge clk) begin
        if (rst) begin
            pub_r <= '0;
            status_one <= 8'h0;
            array_go <= 1'b0;
            array_kind <= KIND_PROG;
            array_addr <= '0;
            array_abort <= 1'b0;
        end else begin
            if (cs_q) begin
                pub_r <= {pd_r, sr3, sr2, sr1};
            end
            status_one <= sr1;
            array_go <= arr_go && !ires;
            if (arr_go) begin
                array_kind <= kind_sel;
                array_addr <= op_addr;
            end
            array_abort <= ires && busy && !sr_op_r; // see R4
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_reset_pair: assert property (sw_go && !ires |=> st_r == ST_SWRST) // see R1
        else $error("reset pair did not start software reset");
    a_swrst_end: assert property ( // see R2
        st_r == ST_SWRST && tmr_r == 32'h0 |=> st_r == ST_IDLE && !wel_r)
        else $error("software reset did not finish to idle");
    a_swrst_quiet: assert property (st_r == ST_SWRST |-> !arr_go && !sr_go) // see R2
        else $error("command taken during software reset");
    a_restart_hold: assert property (hw_hold |=> !wel_r && st_r == ST_IDLE && &lock_r) // see R3
        else $error("restart pulse did not restore power-on state");
    a_puw_block: assert property (!puw_done |-> !wel_r ##1 !array_go) // see R5
        else $error("write enable before power-up delay");
    a_go_needs_wel: assert property ($rose(array_go) |-> $past(wel_r, 1)) // see R7
        else $error("array operation without write enable");
    a_wel_drop: assert property (op_end |=> !wel_r && !busy) // see R8
        else $error("write enable latch not cleared at completion");
    a_pd_filter: assert property ( // see R9
        pd_r && go_frame && cmd_r != OP_RPD |=> !array_go && pd_r)
        else $error("instruction accepted in power-down");
    a_busy_filter: assert property (busy ##1 busy |-> !array_go) // see R15
        else $error("instruction accepted while busy");
    a_lock_guard: assert property (arr_go && wps_r |-> !lock_hit) // see R11
        else $error("locked region written");
    a_range_guard: assert property (arr_go && !wps_r |-> !range_hit) // see R13
        else $error("protected range written");
    a_sr_gate: assert property (sr_go |-> wel_r && !srl_r && (wp_sy_r[1] || !srp_r)) // see R19
        else $error("status write without permission");
    a_pend_cancel: assert property (acc && cmd_r != OP_RSTEN |=> !pend_r) // see R20
        else $error("reset enable kept pending");

    c_sw_reset: cover property (sw_go);
    c_array_op: cover property (array_go ##[1:200] op_end);
    c_status_write: cover property (sr_go);
    c_power_down: cover property (pd_r && acc && cmd_r == OP_RPD);
endmodule : frwp_ctrl

// [frwp_host_model.sv]
// host-side serial master model that drives the flash link
module frwp_host_model (
    output logic spi_sclk,
    output logic spi_cs_n,
    output logic spi_mosi,
    input wire logic spi_miso,
    input wire logic spi_miso_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
    end
    // one frame: opcode then nb bytes of arg, msb first; keeps the last 8 samples
    task automatic xfer(input logic [7:0] op, input logic [31:0] arg, input int nb,
        input logic m3, output logic [7:0] rd, output logic oe);
        logic [39:0] sh;
        sh = {op, arg};
        oe = 1'b1;
        rd = 8'h00;
        #3.7 spi_sclk = m3;
        #80 spi_cs_n = 1'b0;
        #80;
        for (int i = 0; i < 8 * (nb + 1); i++) begin
            spi_sclk = 1'b0;
            spi_mosi = sh[39 - i];
            #80 spi_sclk = 1'b1;
            rd = {rd[6:0], spi_miso};
            if (i >= 8) oe = oe & spi_miso_oe;
            #80;
        end
        spi_sclk = m3;
        #80 spi_cs_n = 1'b1;
        // released data line shows the inverse of its last value
        spi_mosi = ~spi_mosi;
        #400;
    endtask : xfer
endmodule : frwp_host_model

// [frwp_pkg.sv]
// shared constants for the flash reset and write-protect controller
package frwp_pkg;
    localparam int CLK_MHZ = 100;
    localparam int RESTART_MIN_NS = 1000;
    localparam int RESTART_CYC = (RESTART_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int SWRESET_US = 30;
    localparam int SWRESET_CYC = SWRESET_US * CLK_MHZ;
    localparam int ADDR_W = 25;
    localparam int LOCK_BITS = 542;
    localparam int PUB_W = 25;
    localparam int PUB_PD = 24;
    // instruction codes
    localparam logic [7:0] OP_RSTEN = 8'h66;
    localparam logic [7:0] OP_RST = 8'h99;
    localparam logic [7:0] OP_UNLOCK = 8'h39;
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_RDSR1 = 8'h05;
    localparam logic [7:0] OP_RDSR2 = 8'h35;
    localparam logic [7:0] OP_RDSR3 = 8'h15;
    localparam logic [7:0] OP_WRSR1 = 8'h01;
    localparam logic [7:0] OP_WRSR2 = 8'h31;
    localparam logic [7:0] OP_WRSR3 = 8'h11;
    localparam logic [7:0] OP_PROG = 8'h02;
    localparam logic [7:0] OP_SERASE = 8'h20;
    localparam logic [7:0] OP_BERASE = 8'hd8;
    localparam logic [7:0] OP_CERASE = 8'hc7;
    localparam logic [7:0] OP_PDOWN = 8'hb9;
    localparam logic [7:0] OP_RPD = 8'hab;
    // status bit positions
    localparam int SR1_BUSY = 0;
    localparam int SR1_WEL = 1;
    localparam int SR1_BP = 2;
    localparam int SR1_TB = 6;
    localparam int SR1_SRP = 7;
    localparam int SR2_SRL = 0;
    localparam int SR2_CMP = 6;
    localparam int SR3_WPS = 2;
    // array operation kinds
    localparam logic [1:0] KIND_PROG = 2'h0;
    localparam logic [1:0] KIND_SERASE = 2'h1;
    localparam logic [1:0] KIND_BERASE = 2'h2;
    localparam logic [1:0] KIND_CERASE = 2'h3;
    typedef enum logic [1:0] {ST_IDLE, ST_BUSY, ST_SWRST} frwp_st_e;
endpackage : frwp_pkg

// [frwp_spi_link.sv]
// serial link side: byte capture and status shift-out on the host clock
module frwp_spi_link
    import frwp_pkg::*;
(
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    input wire logic [PUB_W-1:0] pub_word,
    output logic [7:0] rx_byte,
    output logic rx_tgl,
    output logic spi_miso,
    output logic spi_miso_oe
);
    logic [2:0] bit_r;
    logic [6:0] sh_r;
    logic first_r;
    logic rd_r;
    logic [1:0] rsel_r;
    logic [7:0] out_r;
    logic tgl_r = 1'b0;

    wire [7:0] in_byte = {sh_r, spi_mosi};
    wire byte_end = bit_r == 3'h7;
    wire [1:0] rsel = (in_byte == OP_RDSR2) ? 2'h1 : (in_byte == OP_RDSR3) ? 2'h2 : 2'h0;
    wire rd_cmd = (in_byte == OP_RDSR1 || in_byte == OP_RDSR2 || in_byte == OP_RDSR3)
        && !pub_word[PUB_PD]; // see R9
    wire [7:0] st_byte = (rsel_r == 2'h1) ? pub_word[15:8] :
        (rsel_r == 2'h2) ? pub_word[23:16] : pub_word[7:0];

    assign rx_tgl = tgl_r;

    // mode 0 and 3 both sample on the rising edge; cs high clears the frame
    always_ff @(posedge spi_sclk or posedge spi_cs_n) begin // see R21
        if (spi_cs_n) begin
            bit_r <= 3'h0;
            sh_r <= 7'h0;
            first_r <= 1'b1;
            rd_r <= 1'b0;
            rsel_r <= 2'h0;
        end else begin
            bit_r <= bit_r + 3'h1;
            sh_r <= in_byte[6:0];
            if (byte_end && first_r) begin
                first_r <= 1'b0;
                rd_r <= rd_cmd;
                rsel_r <= rsel;
            end
        end
    end

    // byte held stable for eight link clocks while the toggle crosses
    always_ff @(posedge spi_sclk) begin
        if (byte_end && !spi_cs_n) begin
            rx_byte <= in_byte;
            tgl_r <= ~tgl_r;
        end
    end

    // status shifts out on falling edges, repeating each byte while selected
    always_ff @(negedge spi_sclk or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            out_r <= 8'h0;
            spi_miso <= 1'b0;
            spi_miso_oe <= 1'b0;
        end else begin
            spi_miso_oe <= rd_r;
            if (rd_r && bit_r == 3'h0) begin
                spi_miso <= st_byte[7];
                out_r <= {st_byte[6:0], 1'b0};
            end else begin
                spi_miso <= out_r[7];
                out_r <= {out_r[6:0], 1'b0};
            end
        end
    end
endmodule : frwp_spi_link

// [tb_flash_reset_and_write_protect.sv]
// self-checking testbench for the flash reset and write-protect controller
module tb_flash_reset_and_write_protect;
    import frwp_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int PUW = 400;
    localparam int SRW = 20;
    logic clk = 0, rst = 1, restart_n = 1, wp_n = 1, supply_ok = 1, array_done = 0;
    logic spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe, array_go, array_abort;
    logic [1:0] array_kind, go_kind;
    logic [ADDR_W-1:0] array_addr, go_addr;
    logic [7:0] status_one, rd;
    logic oe_ok;
    int fails = 0, checked = 0, go_cnt = 0, abort_cnt = 0;
    always #5 clk = ~clk;
    frwp_ctrl #(.PUW_CYC(PUW), .SRW_CYC(SRW)) u_dut (.clk(clk), .rst(rst),
        .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
        .spi_miso_oe(spi_miso_oe), .restart_n(restart_n), .wp_n(wp_n), .supply_ok(supply_ok),
        .array_done(array_done), .array_go(array_go), .array_kind(array_kind),
        .array_addr(array_addr), .array_abort(array_abort), .status_one(status_one));
    frwp_host_model u_host (.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
        .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe));
    always @(posedge clk) begin
        if (array_go === 1'b1) begin
            go_cnt++;
            go_kind = array_kind;
            go_addr = array_addr;
        end
        if (array_abort === 1'b1) abort_cnt++;
    end
    task automatic test_done;
        $display("checks %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : test_done
    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk8
    task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk32
    task automatic cmd(input logic [7:0] op, input logic [31:0] arg = 0, input int nb = 0,
        input logic m3 = 0);
        u_host.xfer(op, arg, nb, m3, rd, oe_ok);
    endtask : cmd
    task automatic sr(input logic [7:0] mask, input logic [7:0] exp);
        @(negedge clk);
        chk8("status_one", exp, status_one & mask);
    endtask : sr
    task automatic wrsr(input logic [7:0] op, input logic [7:0] data);
        cmd(OP_WREN);
        cmd(op, {data, 24'h0}, 1);
        repeat (SRW + 10) @(posedge clk);
    endtask : wrsr
    task automatic done_op;
        @(posedge clk) array_done <= 1'b1;
        @(posedge clk) array_done <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : done_op
    task automatic try_erase(input logic [ADDR_W-1:0] a, input int ok);
        int n;
        n = go_cnt;
        cmd(OP_WREN);
        cmd(OP_SERASE, {7'h0, a}, 4);
        chk32("array_go count", n + ok, go_cnt);
        if (ok == 1) done_op();
    endtask : try_erase
    task automatic t_powerup;
        sr(8'hff, 8'h00);
        cmd(OP_WREN);
        sr(8'h02, 8'h00);
        repeat (PUW) @(posedge clk);
        cmd(OP_WREN);
        sr(8'h02, 8'h02);
        cmd(OP_RDSR1, 0, 1, 1'b1);
        chk8("read status", 8'h02, rd);
        chk8("miso_oe", 8'h01, {7'h0, oe_ok});
    endtask : t_powerup
    task automatic t_program;
        logic [7:0] ops [3] = '{OP_SERASE, OP_BERASE, OP_CERASE};
        cmd(OP_WRDI);
        sr(8'h02, 8'h00);
        cmd(OP_PROG, 32'h0001_2345, 4);
        chk32("array_go count", 0, go_cnt);
        cmd(OP_WREN);
        cmd(OP_PROG, 32'h0001_2345, 4);
        chk32("array_go count", 1, go_cnt);
        chk8("array_kind", {6'h0, KIND_PROG}, {6'h0, go_kind});
        chk32("array_addr", 32'h0001_2345, {7'h0, go_addr});
        sr(8'h03, 8'h03);
        cmd(OP_WRDI);
        sr(8'h02, 8'h02);
        cmd(OP_RDSR1, 0, 1, 1'b1);
        chk8("read status", 8'h03, rd);
        done_op();
        sr(8'h03, 8'h00);
        for (int k = 0; k < 3; k++) begin
            cmd(OP_WREN);
            cmd(ops[k], 32'h0002_0000, k == 2 ? 0 : 4);
            chk8("array_kind", {6'h0, 2'(k + 1)}, {6'h0, go_kind});
            done_op();
            sr(8'h02, 8'h00);
        end
        chk32("array_go count", 4, go_cnt);
    endtask : t_program
    task automatic t_range;
        wrsr(OP_WRSR1, 8'h04);
        sr(8'h7c, 8'h04);
        try_erase(25'h1ff0000, 0);
        try_erase(25'h0000000, 1);
        wrsr(OP_WRSR1, 8'h44);
        try_erase(25'h0000000, 0);
        try_erase(25'h1ff0000, 1);
        wrsr(OP_WRSR2, 8'h40);
        try_erase(25'h0000000, 1);
        try_erase(25'h1ff0000, 0);
        wrsr(OP_WRSR2, 8'h00);
        wrsr(OP_WRSR1, 8'h00);
    endtask : t_range
    task automatic t_locks;
        wrsr(OP_WRSR3, 8'h04);
        try_erase(25'h0001000, 0);
        cmd(OP_UNLOCK, 32'h0000_1000, 4);
        try_erase(25'h0001000, 1);
        try_erase(25'h0000000, 0);
        cmd(OP_UNLOCK, 32'h0010_0000, 4);
        try_erase(25'h010f000, 1);
        wrsr(OP_WRSR3, 8'h00);
        try_erase(25'h0002000, 1);
    endtask : t_locks
    task automatic t_status_lock;
        wrsr(OP_WRSR1, 8'h80);
        @(posedge clk) wp_n <= 1'b0;
        wrsr(OP_WRSR1, 8'h04);
        sr(8'hfc, 8'h80);
        @(posedge clk) wp_n <= 1'b1;
        wrsr(OP_WRSR1, 8'h00);
        sr(8'hfc, 8'h00);
        wrsr(OP_WRSR2, 8'h01);
        wrsr(OP_WRSR1, 8'h04);
        sr(8'hfc, 8'h00);
    endtask : t_status_lock
    task automatic t_supply;
        @(posedge clk) supply_ok <= 1'b0;
        repeat (10) @(posedge clk);
        supply_ok <= 1'b1;
        sr(8'h02, 8'h00);
        cmd(OP_WREN);
        sr(8'h02, 8'h00);
        repeat (PUW) @(posedge clk);
        wrsr(OP_WRSR1, 8'h04);
        sr(8'hfe, 8'h04);
        wrsr(OP_WRSR1, 8'h00);
    endtask : t_supply
    task automatic t_swreset;
        cmd(OP_WREN);
        cmd(OP_RSTEN);
        cmd(OP_WREN);
        cmd(OP_RST);
        cmd(OP_WRDI);
        sr(8'h02, 8'h00);
        cmd(OP_WREN);
        cmd(OP_RSTEN);
        cmd(OP_RST);
        cmd(OP_WRDI);
        sr(8'h02, 8'h02);
        repeat (SWRESET_CYC) @(posedge clk);
        sr(8'h03, 8'h00);
        repeat (PUW) @(posedge clk);
        cmd(OP_WREN);
        sr(8'h02, 8'h02);
    endtask : t_swreset
    task automatic t_restart;
        cmd(OP_PROG, 32'h0003_0000, 4);
        sr(8'h01, 8'h01);
        @(posedge clk) restart_n <= 1'b0;
        repeat (120) @(posedge clk);
        restart_n <= 1'b1;
        repeat (10) @(posedge clk);
        chk32("array_abort count", 1, abort_cnt);
        sr(8'h03, 8'h00);
        repeat (PUW) @(posedge clk);
    endtask : t_restart
    task automatic t_pdown;
        cmd(OP_PDOWN, 0, 0, 1'b1);
        cmd(OP_WREN, 0, 0, 1'b1);
        sr(8'h02, 8'h00);
        cmd(OP_RDSR1, 0, 1, 1'b1);
        chk8("miso_oe", 8'h00, {7'h0, oe_ok});
        cmd(OP_RPD, 0, 0, 1'b1);
        cmd(OP_WREN, 0, 0, 1'b1);
        sr(8'h02, 8'h02);
    endtask : t_pdown
    initial begin
        #1ms;
        fails++;
        test_done();
    end
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_powerup();
        t_program();
        t_range();
        t_locks();
        t_status_lock();
        t_supply();
        t_swreset();
        t_restart();
        t_pdown();
        test_done();
    end
endmodule : tb_flash_reset_and_write_protect
